// [rtl/easb_top.sv]
// Purpose: area 5-7 decode, chip selects, interface pick and 8-bit byte alignment
// Assumes: all of areas 5-7 are 8-bit access space; cycle timing is elsewhere
// Notes: one byte cycle per bus cycle; ext_done from timing logic ends each cycle
`timescale 1ns/100ps

// Operation
// - ram enabled: on-chip ram addresses in area 5 stay internal
// - ram disabled: its range becomes area 5 external space
// - area 5 external except ram and prohibited ranges
// - area 5 chip select asserted low on external accesses
// - area 6 external except internal register range
// - area 6 chip select asserted low on external accesses
// - area 7 external except internal register range
// - area 7 chip select asserted low on external accesses
// - area 5 interface from mux and byte-control bits; 1/1 forbidden
// - area 6 interface from same encoding; 1/1 forbidden
// - area 7 interface from same encoding; 1/1 forbidden
// - accept byte, word and longword requests from internal masters
// - lane choice from size and endian
// - 8-bit space uses only the lower data lane
// - word becomes two byte cycles
// - longword becomes four byte cycles
// - big endian sends most significant byte first
// - little endian sends least significant byte first
module easb_top (
    input wire logic clk, // system clock 20 MHz
    input wire logic rst, // async reset, high
    input wire logic ext_mode, // external extended mode
    input wire logic internal_ram_enable, // on-chip ram enable
    input wire logic area5_mux_select, // area 5 mux interface bit
    input wire logic area6_mux_select, // area 6 mux interface bit
    input wire logic area7_mux_select, // area 7 mux interface bit
    input wire logic area5_bytectl_select, // area 5 byte sram bit
    input wire logic area6_bytectl_select, // area 6 byte sram bit
    input wire logic area7_bytectl_select, // area 7 byte sram bit
    input wire logic req_valid, // master request
    output logic req_ready, // queue has room
    input wire logic req_write, // 1 write, 0 read
    input wire logic [1:0] req_size, // 0 byte, 1 word, 2 long
    input wire logic req_little, // little endian
    input wire logic [23:0] req_addr, // start address
    input wire logic [31:0] req_wdata, // write data
    output logic req_internal, // registered: ram/io hit, no ext cycle
    output logic req_prohibited, // registered: prohibited range hit
    input wire logic ext_done, // timing logic ends current byte cycle
    input wire logic [7:0] ext_rd_pin, // lower lane in, from pins
    output logic [7:0] ext_wd, // lower lane out
    output logic ext_wd_oe_n, // lower lane drive, low drives
    output logic [7:0] ext_upper_wd, // upper lane out, unused here
    output logic ext_upper_oe_n, // upper lane drive, held high
    output logic [23:0] ext_addr, // byte address of cycle
    output logic ext_busy, // byte cycle in progress
    output logic [1:0] ext_iface, // selected protocol
    output logic ext_iface_err, // prohibited 1/1 setting seen
    output logic area5_chip_select_n, // area 5 select, low
    output logic area6_chip_select_n, // area 6 select, low
    output logic area7_chip_select_n, // area 7 select, low
    output logic lower_byte_write_strobe_n, // lower write strobe
    output logic upper_byte_write_strobe_n, // upper write strobe
    output logic lower_byte_select_n, // lower byte select
    output logic upper_byte_select_n, // upper byte select
    output logic rd_valid, // read word done, one cycle
    output logic [31:0] rd_data // assembled read word
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYC = 3'b010,
        ST_NEXT = 3'b100
    } easb_state_t;

    easb_req_if q();
    easb_state_t state_reg;
    logic [easb_pkg::REQ_W-1:0] cur_reg;
    logic [1:0] idx_reg;
    logic [1:0] last_reg;
    logic [2:0] area_reg;
    logic [7:0] rd_s1_reg;
    logic [7:0] rd_s2_reg;
    logic [31:0] acc_reg;
    logic [easb_pkg::REQ_W-1:0] in_word;
    logic [23:0] h_addr;
    logic [2:0] h_area;
    logic h_int;
    logic h_ban;
    logic [1:0] lane;
    logic [1:0] h_last;
    logic c_wr;
    logic c_le;
    logic [31:0] c_data;
    logic [23:0] c_addr;

    ////////////////////////////////////////////////////////////////
    // decode helpers; only in_rng and lane_of are used by more than one process
    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction
    // which of areas 5-7 (one bit each), zero if none
    function automatic logic [2:0] area_of(input logic [23:0] a);
        logic [23:0] b;
        b = a & easb_pkg::AREA_SPAN_MASK;
        area_of = {b == easb_pkg::AREA7_BASE, b == easb_pkg::AREA6_BASE,
                   b == easb_pkg::AREA5_BASE};
    endfunction
    // protocol from mux bit and byte-control bit
    function automatic logic [1:0] iface_of(input logic mux, input logic bc);
        iface_of = {mux, bc};
    endfunction
    // byte order: big endian starts at the top byte
    function automatic logic [1:0] lane_of(input logic le, input logic [1:0] last,
                                           input logic [1:0] idx);
        lane_of = le ? idx : (last - idx);
    endfunction
    function automatic logic [1:0] last_of(input logic [1:0] sz);
        unique case (sz)
            easb_pkg::SZ_WORD: last_of = easb_pkg::LAST_WORD;
            easb_pkg::SZ_LONG: last_of = easb_pkg::LAST_LONG;
            default: last_of = easb_pkg::LAST_BYTE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // request queue; requests of any size enter unchanged
    assign in_word = {req_write, req_size, req_little, req_addr, req_wdata};

    easb_fifo #(.WIDTH(easb_pkg::REQ_W), .DEPTH(easb_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk), .rst(rst), .in_valid(req_valid), .in_ready(req_ready),
        .in_data(in_word), .out(q));

    ////////////////////////////////////////////////////////////////
    // decode of the queue head
    assign h_addr = q.data[easb_pkg::F_ADDR +: easb_pkg::ADDR_W];
    assign h_area = ext_mode ? area_of(h_addr) : 3'h0;
    assign h_int = (h_area[0] && internal_ram_enable
                    && in_rng(h_addr, easb_pkg::RAM_LO, easb_pkg::RAM_HI))
                || (h_area[1] && in_rng(h_addr, easb_pkg::IO6_LO, easb_pkg::IO6_HI))
                || (h_area[2] && in_rng(h_addr, easb_pkg::IO7_LO, easb_pkg::IO7_HI));
    assign h_ban = h_area[0] && in_rng(h_addr, easb_pkg::BAN_LO, easb_pkg::BAN_HI);
    assign h_last = last_of(q.data[easb_pkg::F_SIZE +: 2]);
    // head leaves only when idle; heads with no external cycle are just consumed
    assign q.ready = (state_reg == ST_IDLE);

    assign c_wr = cur_reg[easb_pkg::F_WR];
    assign c_le = cur_reg[easb_pkg::F_LE];
    assign c_data = cur_reg[easb_pkg::F_DATA +: easb_pkg::DATA_W];
    assign c_addr = cur_reg[easb_pkg::F_ADDR +: easb_pkg::ADDR_W];
    assign lane = lane_of(c_le, last_reg, idx_reg);

    ////////////////////////////////////////////////////////////////
    // pin input synchroniser; only the second stage is read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_s1_reg <= 8'h00;
            rd_s2_reg <= 8'h00;
        end
        else
        begin
            rd_s1_reg <= ext_rd_pin;
            rd_s2_reg <= rd_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // byte sequencer: one byte cycle per pass, ends on ext_done
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            cur_reg <= '0;
            idx_reg <= 2'h0;
            last_reg <= 2'h0;
            area_reg <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (q.valid && h_area != 3'h0 && !h_int && !h_ban)
                    begin
                        cur_reg <= q.data;
                        idx_reg <= 2'h0;
                        last_reg <= h_last;
                        area_reg <= h_area;
                        state_reg <= ST_CYC;
                    end
                end
                ST_CYC:
                begin
                    if (ext_done)
                        state_reg <= (idx_reg == last_reg) ? ST_IDLE : ST_NEXT;
                end
                ST_NEXT:
                begin
                    // one idle cycle between byte cycles lets strobes negate
                    idx_reg <= idx_reg + 2'h1;
                    state_reg <= ST_CYC;
                end
            endcase
        end
    end

    // outcome flags for requests that take no external cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            req_internal <= 1'b0;
            req_prohibited <= 1'b0;
        end
        else
        begin
            req_internal <= q.valid && q.ready && h_int;
            req_prohibited <= q.valid && q.ready && h_ban;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin drivers, all registered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            area5_chip_select_n <= 1'b1;
            area6_chip_select_n <= 1'b1;
            area7_chip_select_n <= 1'b1;
            lower_byte_write_strobe_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
            ext_wd <= 8'h00;
            ext_wd_oe_n <= 1'b1;
            ext_addr <= 24'h000000;
            ext_busy <= 1'b0;
            // upper lane never used in 8-bit space: held idle from reset on
            upper_byte_write_strobe_n <= 1'b1;
            upper_byte_select_n <= 1'b1;
            ext_upper_wd <= 8'h00;
            ext_upper_oe_n <= 1'b1;
        end
        else
        begin
            // strobes follow the next state so they open with the cycle
            if ((state_reg == ST_IDLE && q.valid && h_area != 3'h0 && !h_int && !h_ban)
                || state_reg == ST_NEXT || (state_reg == ST_CYC && !ext_done))
            begin
                ext_busy <= 1'b1;
                area5_chip_select_n <= (state_reg == ST_IDLE) ? !h_area[0] : !area_reg[0];
                area6_chip_select_n <= (state_reg == ST_IDLE) ? !h_area[1] : !area_reg[1];
                area7_chip_select_n <= (state_reg == ST_IDLE) ? !h_area[2] : !area_reg[2];
                lower_byte_select_n <= 1'b0;
                if (state_reg == ST_IDLE)
                begin
                    lower_byte_write_strobe_n <= !q.data[easb_pkg::F_WR];
                    ext_wd_oe_n <= !q.data[easb_pkg::F_WR];
                    ext_addr <= h_addr;
                    ext_wd <= q.data[easb_pkg::F_LE]
                        ? q.data[easb_pkg::F_DATA +: 8]
                        : q.data[easb_pkg::F_DATA + 8 * h_last +: 8];
                end
                else if (state_reg == ST_NEXT)
                begin
                    lower_byte_write_strobe_n <= !c_wr;
                    ext_wd_oe_n <= !c_wr;
                    ext_addr <= c_addr + 24'(idx_reg) + 24'h000001;
                    ext_wd <= c_data[8 * lane_of(c_le, last_reg, idx_reg + 2'h1) +: 8];
                end
            end
            else
            begin
                ext_busy <= 1'b0;
                area5_chip_select_n <= 1'b1;
                area6_chip_select_n <= 1'b1;
                area7_chip_select_n <= 1'b1;
                lower_byte_write_strobe_n <= 1'b1;
                lower_byte_select_n <= 1'b1;
                ext_wd_oe_n <= 1'b1;
            end
        end
    end

    // interface pick for the area being accessed; 1/1 flagged, never used
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_iface <= easb_pkg::IF_BASIC;
            ext_iface_err <= 1'b0;
        end
        else
        begin
            logic [1:0] f;
            f = easb_pkg::IF_BASIC;
            if (area_reg[0])
                f = iface_of(area5_mux_select, area5_bytectl_select);
            else if (area_reg[1])
                f = iface_of(area6_mux_select, area6_bytectl_select);
            else if (area_reg[2])
                f = iface_of(area7_mux_select, area7_bytectl_select);
            ext_iface_err <= (f == easb_pkg::IF_BAD);
            ext_iface <= (f == easb_pkg::IF_BAD) ? easb_pkg::IF_BASIC : f;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read assembly: byte lands at its lane slot on ext_done
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 32'h00000000;
            rd_valid <= 1'b0;
            rd_data <= 32'h00000000;
        end
        else
        begin
            rd_valid <= 1'b0;
            if (state_reg == ST_IDLE)
                acc_reg <= 32'h00000000;
            else if (state_reg == ST_CYC && ext_done && !c_wr)
            begin
                acc_reg[8 * lane +: 8] <= rd_s2_reg;
                if (idx_reg == last_reg)
                begin
                    rd_valid <= 1'b1;
                    rd_data <= acc_reg | (32'(rd_s2_reg) << (8 * lane));
                end
            end
        end
    end
endmodule

// [rtl/easb_pkg.sv]
// Purpose: shared constants and types for the area 5-7 select and byte aligner
// Assumes: 24-bit internal address, 8-bit external data lane
// Notes: address ranges are plain defaults
package easb_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    // request word: {write, size, little, addr, data}
    localparam int REQ_W = 1 + 2 + 1 + ADDR_W + DATA_W;
    // area bases and internal windows (plain defaults)
    localparam logic [23:0] AREA5_BASE = 24'ha00000;
    localparam logic [23:0] AREA6_BASE = 24'hc00000;
    localparam logic [23:0] AREA7_BASE = 24'he00000;
    localparam logic [23:0] AREA_SPAN_MASK = 24'he00000;
    localparam logic [23:0] RAM_LO = 24'hbf0000;
    localparam logic [23:0] RAM_HI = 24'hbfbfff;
    localparam logic [23:0] BAN_LO = 24'hbfc000;
    localparam logic [23:0] BAN_HI = 24'hbfffff;
    localparam logic [23:0] IO6_LO = 24'hdfc000;
    localparam logic [23:0] IO6_HI = 24'hdfffff;
    localparam logic [23:0] IO7_LO = 24'hffc000;
    localparam logic [23:0] IO7_HI = 24'hffffff;
    // field positions in the request word
    localparam int F_DATA = 0;
    localparam int F_ADDR = DATA_W;
    localparam int F_LE = DATA_W + ADDR_W;
    localparam int F_SIZE = F_LE + 1;
    localparam int F_WR = F_SIZE + 2;
    // last byte index per size (byte count minus one)
    localparam logic [1:0] LAST_BYTE = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h1;
    localparam logic [1:0] LAST_LONG = 2'h3;
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} easb_size_t;
    typedef enum logic [1:0] {
        IF_BASIC = 2'h0,
        IF_BYTESRAM = 2'h1,
        IF_MUX = 2'h2,
        IF_BAD = 2'h3
    } easb_iface_t;
endpackage

// [rtl/easb_req_if.sv]
// Purpose: valid/ready carrier for queued transfer requests
// Assumes: single clock
// Notes: data layout per easb_pkg field positions
`timescale 1ns/100ps
interface easb_req_if;
    logic valid;
    logic ready;
    logic [easb_pkg::REQ_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// [rtl/easb_fifo.sv]
// Purpose: request queue between the masters and the byte sequencer
// Assumes: flip-flop storage, single clock
// Notes: full drops in_ready so masters stall
`timescale 1ns/100ps
module easb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write word
    easb_req_if.src out // drained side
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////
    // full and empty straight from the count
    assign in_ready = (cnt_reg != (AW + 1)'(DEPTH));
    assign out.valid = (cnt_reg != '0);
    assign out.data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out.valid && out.ready;

    // storage has no reset, only pointers and count do
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_reg] <= in_data;
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// [tb/easb_ext_model.sv]
// Purpose: far-side byte device on the lower data lane
// Assumes: ends each byte cycle WAIT cycles after it opens
// Notes: stall holds a cycle open; idle lane shows the inverted byte
`timescale 1ns/100ps
module easb_ext_model #(
    parameter int WAIT = 4
) (
    input wire logic clk, // system clock
    input wire logic busy, // byte cycle running
    input wire logic wr_n, // lower write strobe
    input wire logic [7:0] addr, // low address byte
    input wire logic [7:0] wd, // write byte
    input wire logic stall, // hold the cycle open
    output logic done, // ends the byte cycle
    output logic [7:0] rd // read byte to pins
);
    logic [7:0] mem [256];
    int cnt = 0;
    initial done = 1'b0;
    initial rd = 8'h00;
    ////////////////////////////////////////////////////////////////
    // pacing; read data settles well before done
    always @(posedge clk)
    begin
        if (busy && !done && !stall)
        begin
            cnt <= cnt + 1;
            done <= (cnt == WAIT - 1);
        end
        else
        begin
            cnt <= 0;
            done <= 1'b0;
        end
        if (busy && done && !wr_n)
            mem[addr] <= wd;
    end
    // lower lane only; inverted value when idle so a stale byte never passes
    always @(posedge clk)
        rd <= busy ? mem[addr] : ~rd;
endmodule

// [tb/easb_chk.sv]
// Purpose: port-level checks of the area select and byte aligner
// Assumes: bound to every easb_top
// Notes: single clock domain
`timescale 1ns/100ps
module easb_chk (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic ext_busy, // byte cycle
    input wire logic ext_done, // cycle end
    input wire logic [23:0] ext_addr, // byte address
    input wire logic [7:0] ext_wd, // lower lane out
    input wire logic ext_wd_oe_n, // lane drive
    input wire logic ext_upper_oe_n, // upper drive
    input wire logic [7:0] ext_upper_wd, // upper out
    input wire logic [1:0] ext_iface, // protocol
    input wire logic area5_chip_select_n, // area 5 select
    input wire logic area6_chip_select_n, // area 6 select
    input wire logic area7_chip_select_n, // area 7 select
    input wire logic lower_byte_write_strobe_n, // lower strobe
    input wire logic upper_byte_write_strobe_n, // upper strobe
    input wire logic lower_byte_select_n, // lower select
    input wire logic upper_byte_select_n, // upper select
    input wire logic req_internal, // internal hit
    input wire logic rd_valid // read word done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    AST_CS5: assert property (!area5_chip_select_n |-> ext_busy && ext_addr[23:21] == 3'h5)
        else $error("area 5 select off cycle");
    AST_CS6: assert property (!area6_chip_select_n |-> ext_busy && ext_addr[23:21] == 3'h6)
        else $error("area 6 select off cycle");
    AST_CS7: assert property (!area7_chip_select_n |-> ext_busy && ext_addr[23:21] == 3'h7)
        else $error("area 7 select off cycle");
    AST_UPPER_IDLE: assert property (upper_byte_write_strobe_n && upper_byte_select_n
        && ext_upper_oe_n && ext_upper_wd == 8'h00)
        else $error("upper lane active");
    AST_LOWER_SEL: assert property (ext_busy |-> !lower_byte_select_n)
        else $error("lower select missing");
    AST_WR_OE: assert property (!lower_byte_write_strobe_n |-> ext_busy && !ext_wd_oe_n)
        else $error("write strobe undriven");
    AST_BYTE_GAP: assert property (ext_busy && ext_done |=> !ext_busy)
        else $error("no gap after byte");
    AST_HOLD: assert property (ext_busy && !ext_done |=>
        ext_busy && $stable(ext_addr) && $stable(ext_wd))
        else $error("byte cycle moved early");
    AST_IFACE: assert property (ext_busy |-> ext_iface != 2'h3)
        else $error("forbidden interface code");
    AST_INT_NOEXT: assert property (req_internal |-> ext_busy == 1'b0)
        else $error("internal hit went external");
    AST_RD_DONE: assert property (rd_valid |-> $past(ext_done))
        else $error("read word without last byte");
    // main scenarios reached
    cover property (rd_valid);
    cover property (ext_busy && !lower_byte_write_strobe_n && ext_done);
    cover property (req_internal);
endmodule

bind easb_top easb_chk u_chk (.*);

// [tb/easb_top_tb.sv]
// Purpose: self-checking bench for the area select and byte aligner
// Assumes: far side modelled by easb_ext_model
// Notes: byte cycles are logged at the edge that ends them
`timescale 1ns/100ps
module easb_top_tb;
    typedef struct packed {
        logic [7:0] wd; logic [23:0] a; logic [2:0] cs; logic [3:0] st; logic [1:0] ifc;
    } easb_rec_t;
    logic clk = 0, rst = 1, ext_mode = 1, internal_ram_enable = 1, stall = 0;
    logic area5_mux_select = 0, area6_mux_select = 0, area7_mux_select = 0;
    logic area5_bytectl_select = 0, area6_bytectl_select = 0, area7_bytectl_select = 0;
    logic req_valid = 0, req_write = 0, req_little = 0, ext_done, ext_wd_oe_n, ext_upper_oe_n;
    logic [1:0] req_size = 0, ext_iface;
    logic [23:0] req_addr = 0, ext_addr;
    logic [31:0] req_wdata = 0, rd_data;
    logic [7:0] ext_rd_pin, ext_wd, ext_upper_wd;
    logic req_ready, req_internal, req_prohibited, ext_busy, ext_iface_err, rd_valid;
    logic area5_chip_select_n, area6_chip_select_n, area7_chip_select_n;
    logic lower_byte_write_strobe_n, upper_byte_write_strobe_n;
    logic lower_byte_select_n, upper_byte_select_n;
    easb_rec_t q[$];
    int error_cnt = 0, checks_done = 0, cyc = 0, int_cnt = 0, pro_cnt = 0;
    easb_top dut (.*);
    easb_ext_model #(.WAIT(4)) u_dev (.clk, .busy(ext_busy), .wr_n(lower_byte_write_strobe_n),
        .addr(ext_addr[7:0]), .wd(ext_wd), .stall, .done(ext_done), .rd(ext_rd_pin));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    // byte cycle log, internal pulse counts, hang guard
    always @(posedge clk)
    begin
        if (ext_busy && ext_done)
            q.push_back({ext_wd, ext_addr, area7_chip_select_n, area6_chip_select_n,
                area5_chip_select_n, upper_byte_write_strobe_n, lower_byte_write_strobe_n,
                upper_byte_select_n, lower_byte_select_n, ext_iface});
        int_cnt += (req_internal === 1'b1);
        pro_cnt += (req_prohibited === 1'b1);
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error: %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until ready is sampled high
    task automatic push(input logic w, input logic [1:0] sz, input logic le,
        input logic [23:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        #1 {req_valid, req_write, req_size, req_little, req_addr, req_wdata} =
            {1'b1, w, sz, le, a, d};
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 200);
        #1 req_valid = 0;
    endtask
    task automatic wait_recs(input int n);
        for (int i = 0; i < 400 && q.size() < n; i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        chk(q.size(), n);
    endtask
    task automatic setif(input int ar, input logic [1:0] c);
        {area5_mux_select, area5_bytectl_select} = (ar == 5) ? c : 2'h0;
        {area6_mux_select, area6_bytectl_select} = (ar == 6) ? c : 2'h0;
        {area7_mux_select, area7_bytectl_select} = (ar == 7) ? c : 2'h0;
    endtask
    ////////////////////////////////////////////////////////////////
    // every size in both byte orders onto the lower lane
    task automatic s_align();
        int n;
        for (int le = 0; le < 2; le++)
            for (int sz = 0; sz < 3; sz++)
            begin
                q.delete();
                n = 1 << sz;
                push(1'b1, 2'(sz), 1'(le), 24'ha00010, 32'h11223344);
                wait_recs(n);
                for (int k = 0; k < n && k < q.size(); k++)
                begin
                    chk(q[k].wd, (32'h11223344 >> 8 * (le ? k : n - 1 - k)) & 32'hff);
                    chk(q[k].a, 24'ha00010 + k);
                    chk(q[k].st, 4'ha);
                    chk(q[k].cs, 3'h6);
                end
            end
    endtask
    // read the long back in both orders
    task automatic s_read();
        int n;
        for (int le = 0; le < 2; le++)
        begin
            n = 0;
            push(1'b0, 2'h2, 1'(le), 24'ha00010, 32'h0);
            do @(posedge clk); while (rd_valid !== 1'b1 && ++n < 400);
            chk(rd_data, le ? 32'h11223344 : 32'h44332211);
        end
    endtask
    // every area with every interface code
    task automatic s_areas();
        for (int ar = 5; ar < 8; ar++)
            for (int c = 0; c < 4; c++)
            begin
                q.delete();
                @(posedge clk);
                #1 setif(ar, 2'(c));
                push(1'b1, 2'h0, 1'b0, {3'(ar), 21'h000100}, 32'h5a);
                wait_recs(1);
                chk(q[0].cs, 32'(~(3'h1 << (ar - 5)) & 3'h7));
                chk(q[0].ifc, (c == 3) ? 2'h0 : 2'(c));
                chk(ext_iface_err, c == 3);
            end
        @(posedge clk);
        #1 setif(5, 2'h0);
    endtask
    // internal ram, prohibited, register windows, unmapped, mode off
    task automatic s_internal();
        logic [23:0] ta [7] = '{24'hbf0010, 24'hbf0010, 24'hbfc000, 24'hdfc004, 24'hffc004,
            24'h200000, 24'ha00020};
        logic [6:0] ram = 7'b1111101, mode = 7'b0111111, ti = 7'b0011001, tp = 7'b0000100;
        for (int i = 0; i < 7; i++)
        begin
            q.delete();
            @(posedge clk);
            #1 {internal_ram_enable, ext_mode, int_cnt, pro_cnt} = {ram[i], mode[i], 64'h0};
            push(1'b1, 2'h0, 1'b0, ta[i], 32'h77);
            repeat (16) @(posedge clk);
            chk(int_cnt, ti[i]);
            chk(pro_cnt, tp[i]);
            chk(q.size(), i == 1);
        end
        @(posedge clk);
        #1 ext_mode = 1;
    endtask
    // queue fills under stall, then drains
    task automatic s_fifo();
        int acc = 0;
        q.delete();
        @(posedge clk);
        #1 {stall, req_valid, req_write, req_size, req_addr} = {3'b111, 2'h0, 24'he00100};
        repeat (24)
        begin
            @(posedge clk);
            acc += (req_ready === 1'b1);
        end
        #1 req_valid = 0;
        chk(req_ready, 0);
        chk(acc >= 16 && acc <= 17, 1);
        stall = 0;
        wait_recs(acc);
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        s_align();
        s_read();
        s_areas();
        s_internal();
        s_fifo();
        wrap_up();
    end
endmodule
